/* rtl/nv_write_ctrl.sv */
// data eeprom write control: control, address, data and bank registers,
// write and read sequencing, write completion flag and interrupt vector request
// assumes the cpu presents one register write per cycle and services
// the vector request by pulsing irq_ack
`timescale 1ns/100ps
`include "nv_write_defs.svh"
module data_eeprom_write_control #(
	parameter int WRITE_TICKS = 4
)(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic tick_async,
	input nv_write_pkg::sfr_write_t addr_wr,
	input nv_write_pkg::sfr_write_t data_wr,
	input nv_write_pkg::sfr_write_t bank_wr,
	input wire logic [7:0] indirect_pointer_1,
	input nv_write_pkg::sfr_write_t indirect_access_port_1,
	input wire logic [7:0] mem_rdata,
	input wire logic nv_interrupt_enable,
	input wire logic global_interrupt_enable,
	input wire logic stack_full,
	input wire logic irq_ack,
	output nv_write_pkg::sfr_view_t view,
	output logic mem_we,
	output logic [5:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic nv_interrupt_flag,
	output logic irq_vector_req
);
	import nv_write_pkg::*;

	typedef struct packed {
		nv_state_t state;
		logic write_enable_bit;
		logic wr;
		logic read_enable_bit;
		logic rd;
		logic [5:0] addr;
		logic [7:0] data;
		logic [7:0] bank;
		logic [3:0] rcount;
		logic flag;
		logic vec;
		logic we;
		logic timer_start;
	} ctrl_state_t;
	ctrl_state_t s_reg, s_next;
	logic timer_done;
	logic ctl_sel;
	logic [7:0] cw;

	nv_write_timer #(
		.TICKS(WRITE_TICKS)
	) u_timer (
		.clock(clock),
		.rst_n(rst_n),
		.tick_async(tick_async),
		.start(s_reg.timer_start),
		.done(timer_done)
	);

	// ----------------------------------------
	// register and sequence logic
	// ----------------------------------------
	always_comb
	begin
		s_next = s_reg;
		s_next.we = 1'b0;
		s_next.timer_start = 1'b0;
		cw = indirect_access_port_1.wdata;
		// control reachable only at pointer 40h in bank 1
		ctl_sel = indirect_access_port_1.wr_en && (s_reg.bank == `CTL_BANK)
			&& (indirect_pointer_1 == `CTL_INDIRECT_ADDR);
		if (bank_wr.wr_en)
			s_next.bank = bank_wr.wdata;
		// address and data frozen while busy
		if (s_reg.state == ST_IDLE)
		begin
			if (addr_wr.wr_en)
				s_next.addr = addr_wr.wdata[5:0];
			if (data_wr.wr_en)
				s_next.data = data_wr.wdata;
		end
		if (ctl_sel)
		begin
			s_next.write_enable_bit = cw[`CTL_WRITE_ENABLE_BIT_POS];
			s_next.read_enable_bit = cw[`CTL_READ_ENABLE_BIT_POS];
			// triggers can be cleared by software only when idle; busy bits stick
			if (s_reg.state == ST_IDLE)
			begin
				s_next.wr = 1'b0;
				s_next.rd = 1'b0;
				if (cw[`CTL_WR_POS] && s_reg.write_enable_bit)
				begin
					s_next.wr = 1'b1;
					s_next.state = ST_WRITE;
					s_next.we = 1'b1;
					s_next.timer_start = 1'b1;
				end
				else if (cw[`CTL_RD_POS] && s_reg.read_enable_bit)
				begin
					s_next.rd = 1'b1;
					s_next.state = ST_READ;
					s_next.rcount = 4'h0;
				end
			end
		end
		case (s_reg.state)
			ST_WRITE:
			begin
				if (timer_done)
				begin
					s_next.wr = 1'b0;
					s_next.state = ST_IDLE;
				end
			end
			ST_READ:
			begin
				if (s_reg.rcount == `READ_CYCLES)
				begin
					s_next.data = mem_rdata;
					s_next.rd = 1'b0;
					s_next.state = ST_IDLE;
				end
				else
					s_next.rcount = s_reg.rcount + 4'h1;
			end
			default:
			begin
			end
		endcase
		if (irq_ack)
			s_next.flag = 1'b0;
		if (s_reg.state == ST_WRITE && timer_done)
			s_next.flag = 1'b1;
		s_next.vec = s_next.flag && nv_interrupt_enable && global_interrupt_enable
			&& !stack_full && !irq_ack;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			s_reg <= '0;
			s_reg.state <= ST_IDLE;
			s_reg.bank <= `BANK_RESET;
			s_reg.data <= `DATA_RESET;
			s_reg.addr <= `ADDR_RESET;
		end
		else
			s_reg <= s_next;
	end

	assign view.control = {4'h0, s_reg.write_enable_bit, s_reg.wr,
		s_reg.read_enable_bit, s_reg.rd};
	assign view.address = {2'b00, s_reg.addr};
	assign view.data = s_reg.data;
	assign view.bank = s_reg.bank;
	assign mem_we = s_reg.we;
	assign mem_addr = s_reg.addr;
	assign mem_wdata = s_reg.data;
	assign nv_interrupt_flag = s_reg.flag;
	assign irq_vector_req = s_reg.vec;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_no_start_without_enable;
		@(posedge clock) disable iff (!rst_n)
		(ctl_sel && cw[`CTL_WR_POS] && !s_reg.write_enable_bit
		&& s_reg.state == ST_IDLE) |=> !s_reg.wr;
	endproperty
	a_no_start_without_enable: assert property (p_no_start_without_enable)
		else $error("write started without enable");

	sequence s_start;
		ctl_sel && cw[`CTL_WR_POS] && s_reg.write_enable_bit && s_reg.state == ST_IDLE;
	endsequence
	property p_start_pulses;
		@(posedge clock) disable iff (!rst_n)
		s_start |=> s_reg.wr && mem_we ##1 !mem_we;
	endproperty
	a_start_pulses: assert property (p_start_pulses)
		else $error("write start did not pulse memory strobe");

	property p_wr_clears;
		@(posedge clock) disable iff (!rst_n)
		(s_reg.state == ST_WRITE && timer_done) |=> !s_reg.wr && nv_interrupt_flag;
	endproperty
	a_wr_clears: assert property (p_wr_clears)
		else $error("trigger not cleared or flag not set at write end");

	property p_reset_vals;
		@(posedge clock) !rst_n |=> view.control == `CTL_RESET && view.bank == `BANK_RESET;
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("control or bank not zero after reset");

	property p_bank_guard;
		@(posedge clock) disable iff (!rst_n)
		(indirect_access_port_1.wr_en && s_reg.bank != `CTL_BANK)
		|=> $stable(view.control[`CTL_WRITE_ENABLE_BIT_POS]) && $stable(view.control[`CTL_READ_ENABLE_BIT_POS]);
	endproperty
	a_bank_guard: assert property (p_bank_guard)
		else $error("control reached outside bank 1");

	property p_vector;
		@(posedge clock) disable iff (!rst_n)
		irq_vector_req |-> nv_interrupt_flag && !$past(stack_full)
		&& $past(global_interrupt_enable) && $past(nv_interrupt_enable);
	endproperty
	a_vector: assert property (p_vector)
		else $error("vector request without cause");

	property p_ack_clears;
		@(posedge clock) disable iff (!rst_n)
		(irq_ack && !(s_reg.state == ST_WRITE && timer_done)) |=> !nv_interrupt_flag;
	endproperty
	a_ack_clears: assert property (p_ack_clears)
		else $error("flag survived service");

	property p_upper_zero;
		@(posedge clock) disable iff (!rst_n)
		view.control[7:4] == 4'h0 && view.address[7:6] == 2'b00;
	endproperty
	a_upper_zero: assert property (p_upper_zero)
		else $error("unimplemented bits not zero");

	property p_frozen;
		@(posedge clock) disable iff (!rst_n)
		(s_reg.state == ST_WRITE && s_next.state == ST_WRITE) |=> $stable(mem_wdata)
		&& $stable(mem_addr);
	endproperty
	a_frozen: assert property (p_frozen)
		else $error("address or data changed during write");
endmodule

/* rtl/nv_write_defs.svh */
// constants of the data eeprom write control block
// assumes one synchronous clock domain and an 8-bit special register path
`ifndef NV_WRITE_DEFS_SVH
`define NV_WRITE_DEFS_SVH
`define CTL_WRITE_ENABLE_BIT_POS 3
`define CTL_WR_POS 2
`define CTL_READ_ENABLE_BIT_POS 1
`define CTL_RD_POS 0
`define CTL_RESET 8'h00
`define DATA_RESET 8'h00
`define ADDR_RESET 6'h00
`define BANK_RESET 8'h00
`define CTL_BANK 8'h01
`define CTL_INDIRECT_ADDR 8'h40
`define READ_CYCLES 4'h2
`endif

/* rtl/nv_write_pkg.sv */
// types shared by the data eeprom write control block
package nv_write_pkg;
	typedef struct packed {
		logic wr_en;
		logic [7:0] wdata;
	} sfr_write_t;
	typedef struct packed {
		logic [7:0] control;
		logic [7:0] address;
		logic [7:0] data;
		logic [7:0] bank;
	} sfr_view_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WRITE = 3'b010,
		ST_READ = 3'b100
	} nv_state_t;
endpackage

/* rtl/nv_write_timer.sv */
// write cycle timer: a free-running slow tick from another oscillator is
// brought in through a two-stage synchroniser and counted
// assumes tick_async toggles at its own rate, unrelated to clock
`timescale 1ns/100ps
module nv_write_timer #(
	parameter int TICKS = 4
)(
	input wire logic clock,
	input wire logic rst_n,
	input wire logic tick_async,
	input wire logic start,
	output logic done
);
	typedef struct packed {
		logic sync1;
		logic sync2;
		logic last;
		logic run;
		logic [7:0] count;
		logic done;
	} timer_state_t;
	timer_state_t st_reg, st_next;

	always_comb
	begin
		st_next = st_reg;
		st_next.sync1 = tick_async;
		st_next.sync2 = st_reg.sync1;
		st_next.last = st_reg.sync2;
		st_next.done = 1'b0;
		if (start)
		begin
			st_next.run = 1'b1;
			st_next.count = 8'h00;
		end
		else if (st_reg.run && (st_reg.sync2 != st_reg.last))
		begin
			if (st_reg.count == 8'(TICKS - 1))
			begin
				st_next.run = 1'b0;
				st_next.done = 1'b1;
			end
			else
				st_next.count = st_reg.count + 8'h01;
		end
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
			st_reg <= '0;
		else
			st_reg <= st_next;
	end

	assign done = st_reg.done;
endmodule

/* verification/nv_write_tb.sv */
// self-checking bench for the data eeprom write control block
// assumes registered outputs and a write time of WRITE_TICKS slow tick edges
`timescale 1ns/100ps
module testbench;
	import nv_write_pkg::*;
	logic clock, rst_n, nv_interrupt_enable, global_interrupt_enable;
	logic stack_full, irq_ack, mem_we, nv_interrupt_flag, irq_vector_req;
	logic tick_async = 1'b0;
	logic [7:0] indirect_pointer_1, mem_wdata, we_data;
	logic [7:0] mem_rdata = 8'h00;
	logic [7:0] nv_array [64];
	logic [5:0] mem_addr, we_addr;
	sfr_write_t addr_wr, data_wr, bank_wr, port_wr;
	sfr_view_t view;
	int fails, samples_checked;
	int cycles = 0;
	int we_count = 0;

	data_eeprom_write_control #(.WRITE_TICKS(2)) u_dut (.clock(clock), .rst_n(rst_n),
		.tick_async(tick_async), .addr_wr(addr_wr), .data_wr(data_wr), .bank_wr(bank_wr),
		.indirect_pointer_1(indirect_pointer_1), .indirect_access_port_1(port_wr),
		.mem_rdata(mem_rdata), .nv_interrupt_enable(nv_interrupt_enable),
		.global_interrupt_enable(global_interrupt_enable), .stack_full(stack_full),
		.irq_ack(irq_ack), .view(view), .mem_we(mem_we), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .nv_interrupt_flag(nv_interrupt_flag),
		.irq_vector_req(irq_vector_req));

	initial
	begin
		clock = 0;
		forever #2 clock = ~clock;
	end

	// ----------------------------------------
	// slow tick, array model, write monitor, timeout
	// ----------------------------------------
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		mem_rdata <= nv_array[mem_addr];
		if (cycles % 6 == 5)
			tick_async <= ~tick_async;
		if (mem_we === 1'b1)
		begin
			we_count <= we_count + 1;
			we_addr <= mem_addr;
			we_data <= mem_wdata;
			nv_array[mem_addr] <= mem_wdata;
		end
		if (cycles == 4000)
		begin
			fails = fails + 1;
			results();
		end
	end

	task results;
		if (fails == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			fails++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one-cycle register write: 0 address, 1 data, 2 bank, 3 indirect port
	task put(input int k, input logic [7:0] v);
		@(posedge clock);
		case (k)
			0: addr_wr <= '{1'b1, v};
			1: data_wr <= '{1'b1, v};
			2: bank_wr <= '{1'b1, v};
			default: port_wr <= '{1'b1, v};
		endcase
		@(posedge clock);
		addr_wr.wr_en <= 1'b0;
		data_wr.wr_en <= 1'b0;
		bank_wr.wr_en <= 1'b0;
		port_wr.wr_en <= 1'b0;
		#1;
	endtask

	task t_guard;
		put(3, 8'h08);
		chk(view.control, 8'h00);
		put(2, 8'h01);
		@(posedge clock);
		indirect_pointer_1 <= 8'h41;
		put(3, 8'h08);
		chk(view.control, 8'h00);
		@(posedge clock);
		indirect_pointer_1 <= 8'h40;
		put(0, 8'hff);
		chk(view.address, 8'h3f);
		put(3, 8'hf4);
		chk({view.control, 24'(we_count)}, 32'h0);
	endtask

	task t_write(input logic [7:0] a, input logic [7:0] d, input logic full);
		int n;
		stack_full <= full;
		put(0, a);
		put(1, d);
		put(3, 8'hf8);
		chk(view.control, 8'h08);
		n = we_count;
		global_interrupt_enable <= 1'b0;
		put(3, 8'h0c);
		global_interrupt_enable <= 1'b1;
		put(1, ~d);
		chk(view.data, d);
		for (int i = 0; i < 200 && view.control[2] === 1'b1; i++)
		begin
			@(posedge clock);
			#1;
		end
		chk({view.control, 7'h0, nv_interrupt_flag}, {8'h08, 8'h01});
		chk({16'(we_count - n), 2'h0, we_addr, we_data}, {16'h0001, 2'h0, a[5:0], d});
		@(posedge clock);
		#1;
		chk(irq_vector_req, !full);
		irq_ack <= 1'b1;
		@(posedge clock);
		irq_ack <= 1'b0;
		@(posedge clock);
		#1;
		chk({nv_interrupt_flag, irq_vector_req}, 2'b00);
	endtask

	task t_read;
		put(3, 8'h02);
		put(0, 8'h3f);
		put(3, 8'h03);
		for (int i = 0; i < 50 && view.control[0] === 1'b1; i++)
		begin
			@(posedge clock);
			#1;
		end
		chk({view.control, view.data}, {8'h02, 8'h5a});
		put(3, 8'h00);
		put(2, 8'h00);
		chk({view.control, view.bank}, 16'h0);
	endtask

	// a reset in mid-run must drop an enable that software had set
	task t_reset;
		put(2, 8'h01);
		put(3, 8'h08);
		chk(view.control, 8'h08);
		@(posedge clock);
		rst_n <= 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		#1;
		chk({view.control, view.bank}, 16'h0);
	endtask

	initial
	begin
		{rst_n, stack_full, irq_ack, fails} = '0;
		{addr_wr, data_wr, bank_wr, port_wr, samples_checked} = '0;
		{nv_interrupt_enable, global_interrupt_enable} = 2'b11;
		indirect_pointer_1 = 8'h40;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		#1;
		chk(view, 32'h0);
		chk({mem_we, nv_interrupt_flag, irq_vector_req}, 3'h0);
		t_guard();
		t_write(8'hea, 8'ha5, 1'b0);
		t_write(8'h3f, 8'h5a, 1'b1);
		t_read();
		t_reset();
		results();
	end
endmodule
